/* rtl/low_power_state_control.sv */
// Power-management state control: clock-stop grant, sleep and system-management entry
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "lps_map.svh"

module low_power_state_control (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Power-management inputs, asynchronous, active low
  input wire logic CLOCK_STOP_REQUEST_N_I,
  input wire logic SLEEP_REQUEST_N_I,
  input wire logic SYSMGMT_INTERRUPT_N_I,
  // Incoming interrupt and bus snoop
  input wire logic INTR_I,
  input wire logic SNOOP_REQ_I,
  output logic SNOOP_ACK_O,
  // Clock gating enables
  output logic CORE_CLK_EN_O,
  output logic BUS_CLK_EN_O,
  output logic LIC_CLK_EN_O,
  output logic PLL_EN_O,
  // Acknowledge transaction to the bus unit
  output logic ACK_VALID_O,
  output logic [1:0] ACK_TYPE_O,
  input wire logic ACK_READY_I,
  // Execution control
  output logic EXEC_RUN_O,
  output logic SAVE_STATE_O,
  output logic HANDLER_FETCH_O,
  output logic INTR_SERVICE_O,
  output logic SYSMGMT_OPERATING_MODE_O,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`LPS_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  logic [`LPS_SYNC_W-1:0] async_n;
  logic [`LPS_SYNC_W-1:0] sync_n;

  // Lanes packed for the synchroniser
  assign async_n[`LPS_LANE_STOP] = CLOCK_STOP_REQUEST_N_I;
  assign async_n[`LPS_LANE_SLEEP] = SLEEP_REQUEST_N_I;
  assign async_n[`LPS_LANE_SMI] = SYSMGMT_INTERRUPT_N_I;

  pm_sync u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .async_n_i(async_n),
    .sync_n_o(sync_n)
  );

  logic stop_req;
  logic sleep_req;
  logic smi_lvl;
  assign stop_req = ~sync_n[`LPS_LANE_STOP];
  assign sleep_req = ~sync_n[`LPS_LANE_SLEEP];
  assign smi_lvl = ~sync_n[`LPS_LANE_SMI];

  // ------------------------------------------------------------
  // State and control registers
  // ------------------------------------------------------------
  lps_pkg::pm_state_t state_r;
  lps_pkg::pm_state_t state_nxt;
  logic smi_prev_r;
  logic smi_pend_r;
  logic smi_pend_nxt;
  logic intr_pend_r;
  logic intr_pend_nxt;
  logic smm_r;
  logic smm_nxt;
  logic smi_en_r;
  logic snoop_ack_r;
  logic save_r;
  logic fetch_r;
  logic service_r;
  logic [31:0] prdata_r;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire setup_ph = PSEL && !PENABLE;
  wire access_ph = PSEL && PENABLE;
  wire hit_ctrl = (PADDR == `LPS_CTRL_OFF);
  wire hit_stat = (PADDR == `LPS_STAT_OFF);
  wire hit_any = hit_ctrl || hit_stat;
  wire wr_ctrl = access_ph && PWRITE && hit_ctrl;
  wire smm_exit = wr_ctrl && PWDATA[`LPS_CTRL_SMM_EXIT_BIT];

  // ------------------------------------------------------------
  // Derived state decodes
  // ------------------------------------------------------------
  wire in_grant = (state_r == lps_pkg::ST_GRANT) || (state_r == lps_pkg::ST_GRANT_ACK);
  wire in_sleep = (state_r == lps_pkg::ST_SLEEP);
  wire in_run = (state_r == lps_pkg::ST_RUN);
  wire smi_edge = smi_lvl && !smi_prev_r;
  wire ack_done = ACK_VALID_O && ACK_READY_I;

  // Clock enables: core only runs outside grant and sleep
  assign CORE_CLK_EN_O = !in_grant && !in_sleep;
  assign BUS_CLK_EN_O = !in_sleep;
  assign LIC_CLK_EN_O = !in_sleep;
  assign PLL_EN_O = 1'b1;

  // Acknowledge transaction request, held until taken
  assign ACK_VALID_O = (state_r == lps_pkg::ST_GRANT_ACK) || (state_r == lps_pkg::ST_SMI_ACK);
  assign ACK_TYPE_O = (state_r == lps_pkg::ST_GRANT_ACK) ? `LPS_ACK_GRANT :
                      (state_r == lps_pkg::ST_SMI_ACK) ? `LPS_ACK_SMI :
                      `LPS_ACK_NONE;
  assign EXEC_RUN_O = in_run;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lps_pkg::ST_RUN: begin
        if (stop_req) begin
          state_nxt = lps_pkg::ST_GRANT_ACK;
        end else if (smi_pend_r && smi_en_r && !smm_r) begin
          state_nxt = lps_pkg::ST_SMI_SAVE;
        end
      end
      lps_pkg::ST_GRANT_ACK: begin
        // Sleep request not heeded until the grant ack is taken
        if (ack_done) begin
          state_nxt = lps_pkg::ST_GRANT;
        end
      end
      lps_pkg::ST_GRANT: begin
        if (sleep_req) begin
          state_nxt = lps_pkg::ST_SLEEP;
        end else if (!stop_req) begin
          state_nxt = lps_pkg::ST_RESUME;
        end
      end
      lps_pkg::ST_SLEEP: begin
        // Only the sleep request releases sleep; clock-stop is acted on in grant
        if (!sleep_req) begin
          state_nxt = lps_pkg::ST_GRANT;
        end
      end
      lps_pkg::ST_RESUME: begin
        // Latched interrupts are serviced in the same cycle that execution restarts
        state_nxt = lps_pkg::ST_RUN;
      end
      lps_pkg::ST_SMI_SAVE: begin
        state_nxt = lps_pkg::ST_SMI_ACK;
      end
      lps_pkg::ST_SMI_ACK: begin
        if (ack_done) begin
          state_nxt = lps_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = lps_pkg::ST_RUN;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Pending flags and mode
  // ------------------------------------------------------------
  // Interrupts latch only in grant; sleep drops them; set wins over clear
  assign intr_pend_nxt = (in_grant && INTR_I) ? 1'b1 :
                         (state_r == lps_pkg::ST_RESUME) ? 1'b0 :
                         intr_pend_r;
  // Interrupt edges outside sleep are held until taken; set wins over the accept
  assign smi_pend_nxt = (smi_edge && !in_sleep) ? 1'b1 :
                        (state_r == lps_pkg::ST_SMI_SAVE) ? 1'b0 :
                        smi_pend_r;
  assign smm_nxt = (state_r == lps_pkg::ST_SMI_SAVE) ? 1'b1 :
                   smm_exit ? 1'b0 :
                   smm_r;

  // State register
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= lps_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Flag registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      smi_prev_r <= 1'b0;
      smi_pend_r <= 1'b0;
      intr_pend_r <= 1'b0;
      smm_r <= 1'b0;
    end else begin
      smi_prev_r <= smi_lvl;
      smi_pend_r <= smi_pend_nxt;
      intr_pend_r <= intr_pend_nxt;
      smm_r <= smm_nxt;
    end
  end

  // ------------------------------------------------------------
  // Execution pulses and snoop answer
  // ------------------------------------------------------------
  wire save_nxt = (state_r == lps_pkg::ST_SMI_SAVE);
  wire fetch_nxt = (state_r == lps_pkg::ST_SMI_ACK) && ack_done;
  wire service_nxt = (state_r == lps_pkg::ST_RESUME) && intr_pend_r;
  wire snoop_nxt = SNOOP_REQ_I && !in_sleep;

  // Pulses one cycle after their cause
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      save_r <= 1'b0;
      fetch_r <= 1'b0;
      service_r <= 1'b0;
      snoop_ack_r <= 1'b0;
    end else begin
      save_r <= save_nxt;
      fetch_r <= fetch_nxt;
      service_r <= service_nxt;
      snoop_ack_r <= snoop_nxt;
    end
  end

  // Pulse and level outputs straight from flip-flops
  assign SAVE_STATE_O = save_r;
  assign HANDLER_FETCH_O = fetch_r;
  assign INTR_SERVICE_O = service_r;
  assign SNOOP_ACK_O = snoop_ack_r;
  assign SYSMGMT_OPERATING_MODE_O = smm_r;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // Interrupt acceptance enable
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      smi_en_r <= `LPS_CTRL_SMI_EN_RST;
    end else if (wr_ctrl) begin
      smi_en_r <= PWDATA[`LPS_CTRL_SMI_EN_BIT];
    end
  end

  // Read values
  logic [31:0] stat_val;
  logic [31:0] ctrl_val;
  always_comb begin
    stat_val = 32'h00000000;
    stat_val[`LPS_STAT_CORE_CLK_BIT] = CORE_CLK_EN_O;
    stat_val[`LPS_STAT_BUS_CLK_BIT] = BUS_CLK_EN_O;
    stat_val[`LPS_STAT_LIC_CLK_BIT] = LIC_CLK_EN_O;
    stat_val[`LPS_STAT_SMM_BIT] = smm_r;
    stat_val[`LPS_STAT_INTR_PEND_BIT] = intr_pend_r;
    stat_val[`LPS_STAT_SMI_PEND_BIT] = smi_pend_r;
    stat_val[`LPS_STAT_GRANT_BIT] = in_grant;
    stat_val[`LPS_STAT_SLEEP_BIT] = in_sleep;
    ctrl_val = 32'h00000000;
    ctrl_val[`LPS_CTRL_SMI_EN_BIT] = smi_en_r;
  end

  wire [31:0] rd_mux = hit_ctrl ? ctrl_val : (hit_stat ? stat_val : 32'h00000000);

  // Read data captured in the setup phase
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prdata_r <= 32'h00000000;
    end else if (setup_ph && !PWRITE) begin
      prdata_r <= rd_mux;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign PRDATA = prdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = access_ph && !hit_any;

endmodule : low_power_state_control

/* rtl/lps_map.svh */
// Offsets, field positions and reset values for the power state control block
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define LPS_ADDR_W 12
`define LPS_CTRL_OFF 12'h000
`define LPS_STAT_OFF 12'h004

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define LPS_CTRL_SMI_EN_BIT 0
`define LPS_CTRL_SMM_EXIT_BIT 1
`define LPS_CTRL_SMI_EN_RST 1'h1

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define LPS_STAT_CORE_CLK_BIT 0
`define LPS_STAT_BUS_CLK_BIT 1
`define LPS_STAT_LIC_CLK_BIT 2
`define LPS_STAT_SMM_BIT 3
`define LPS_STAT_INTR_PEND_BIT 4
`define LPS_STAT_SMI_PEND_BIT 5
`define LPS_STAT_GRANT_BIT 6
`define LPS_STAT_SLEEP_BIT 7

// ------------------------------------------------------------
// Synchroniser lanes and acknowledge codes
// ------------------------------------------------------------
`define LPS_SYNC_W 3
`define LPS_LANE_STOP 0
`define LPS_LANE_SLEEP 1
`define LPS_LANE_SMI 2
`define LPS_ACK_NONE 2'h0
`define LPS_ACK_GRANT 2'h1
`define LPS_ACK_SMI 2'h2

`endif

/* rtl/lps_pkg.sv */
// Types shared by the power state control block
package lps_pkg;

  // ------------------------------------------------------------
  // Power state machine
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN,
    ST_GRANT_ACK,
    ST_GRANT,
    ST_SLEEP,
    ST_RESUME,
    ST_SMI_SAVE,
    ST_SMI_ACK
  } pm_state_t;

endpackage : lps_pkg

/* rtl/pm_sync.sv */
// Two-stage synchroniser for the asynchronous power-management inputs
`timescale 1ns/10ps
`include "lps_map.svh"

module pm_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [`LPS_SYNC_W-1:0] async_n_i,
  output logic [`LPS_SYNC_W-1:0] sync_n_o
);

  // ------------------------------------------------------------
  // One synchroniser per lane
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `LPS_SYNC_W; g = g + 1) begin : g_lane
      logic meta_r;
      logic sync_r;
      // Inactive (high) at reset; first stage feeds only the second
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_r <= 1'b1;
          sync_r <= 1'b1;
        end else begin
          meta_r <= async_n_i[g];
          sync_r <= meta_r;
        end
      end
      assign sync_n_o[g] = sync_r;
    end
  endgenerate

endmodule : pm_sync

/* verif/lps_monitor.sv */
// Port-level checker of the power state control block
`timescale 1ns/10ps
module lps_monitor (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CLOCK_STOP_REQUEST_N_I,
  input wire logic SNOOP_REQ_I,
  input wire logic SNOOP_ACK_O,
  input wire logic CORE_CLK_EN_O,
  input wire logic BUS_CLK_EN_O,
  input wire logic LIC_CLK_EN_O,
  input wire logic PLL_EN_O,
  input wire logic ACK_VALID_O,
  input wire logic [1:0] ACK_TYPE_O,
  input wire logic ACK_READY_I,
  input wire logic EXEC_RUN_O,
  input wire logic SAVE_STATE_O,
  input wire logic HANDLER_FETCH_O,
  input wire logic SYSMGMT_OPERATING_MODE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic smi_taken_r;
  // ------------------------------------------------------------
  // System-management ack taken last cycle
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) smi_taken_r <= 1'b0;
    else smi_taken_r <= ACK_VALID_O && ACK_READY_I && ACK_TYPE_O == 2'h2;
  end
  chk_pll_running: assert property (PLL_EN_O)
    else $error("pll stopped");
  chk_sleep_clocks: assert property (!BUS_CLK_EN_O |-> !CORE_CLK_EN_O && !LIC_CLK_EN_O)
    else $error("unit clock running in sleep");
  chk_sleep_snoop: assert property (!BUS_CLK_EN_O && !$past(BUS_CLK_EN_O) |-> !SNOOP_ACK_O)
    else $error("snoop answered in sleep");
  chk_snoop_kept: assert property ((SNOOP_REQ_I && BUS_CLK_EN_O) ##1 BUS_CLK_EN_O
    |-> SNOOP_ACK_O)
    else $error("snoop not answered");
  chk_sleep_entry: assert property ($fell(BUS_CLK_EN_O)
    |-> !$past(CORE_CLK_EN_O) && !$past(ACK_VALID_O))
    else $error("sleep entered outside grant");
  chk_stop_grant: assert property (($fell(CLOCK_STOP_REQUEST_N_I) && EXEC_RUN_O)
    ##1 !CLOCK_STOP_REQUEST_N_I [*2] |-> ##[0:3] (ACK_VALID_O && ACK_TYPE_O == 2'h1))
    else $error("no grant ack after stop");
  chk_grant_clocks: assert property (ACK_VALID_O && ACK_TYPE_O == 2'h1
    |-> !CORE_CLK_EN_O && BUS_CLK_EN_O && LIC_CLK_EN_O)
    else $error("grant clock gating wrong");
  chk_ack_hold: assert property (ACK_VALID_O && !ACK_READY_I
    |=> ACK_VALID_O && $stable(ACK_TYPE_O))
    else $error("ack dropped before taken");
  chk_smi_save: assert property (SAVE_STATE_O
    |-> SYSMGMT_OPERATING_MODE_O && ACK_VALID_O && ACK_TYPE_O == 2'h2)
    else $error("state save without mode");
  chk_fetch_ack: assert property (HANDLER_FETCH_O == smi_taken_r)
    else $error("handler fetch not after ack");
  cover property (ACK_VALID_O && !ACK_READY_I);
  cover property (!BUS_CLK_EN_O);
  cover property (HANDLER_FETCH_O);
endmodule : lps_monitor

/* verif/chipset_model.sv */
// System-side model driving the power pins and taking acks
`timescale 1ns/10ps
module chipset_model (
  input wire logic clk_i,
  input wire logic stop_i,
  input wire logic sleep_i,
  input wire logic smi_i,
  input wire logic slow_i,
  input wire logic ack_valid_i,
  output logic stop_n_o = 1'b1,
  output logic sleep_n_o = 1'b1,
  output logic smi_n_o = 1'b1,
  output logic ack_ready_o
);
  logic [1:0] wait_r = 2'h0;
  // Pins follow requests, free of any bus timing
  always @(posedge clk_i) begin
    stop_n_o <= !stop_i;
    sleep_n_o <= !sleep_i;
    smi_n_o <= !smi_i;
    wait_r <= ack_valid_i ? wait_r + 2'h1 : 2'h0;
  end
  // Ack taken at once, or after three waits when slow
  assign ack_ready_o = ack_valid_i && (!slow_i || wait_r == 2'h3);
endmodule : chipset_model

/* verif/testbench.sv */
// Self-checking bench of the power state control block
`timescale 1ns/10ps
`include "lps_map.svh"
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, stop = 1'b0, sleep = 1'b0, smi = 1'b0, slow = 1'b0;
  logic intr = 1'b0, snoop = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [`LPS_ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, d, rnd = 32'hA9AE8614;
  logic stop_n, sleep_n, smi_n, rdy, snp, core, bus, lic, pll, ackv, run, save, fetch, isrv;
  logic mode, pready, pslverr;
  logic [1:0] ackt;
  int error_cnt = 0, n_tests = 0;
  low_power_state_control low_power_state_control_inst (.CLK_I(clk), .RST_N_I(rst_n),
    .CLOCK_STOP_REQUEST_N_I(stop_n), .SLEEP_REQUEST_N_I(sleep_n), .SYSMGMT_INTERRUPT_N_I(smi_n),
    .INTR_I(intr), .SNOOP_REQ_I(snoop), .SNOOP_ACK_O(snp), .CORE_CLK_EN_O(core),
    .BUS_CLK_EN_O(bus), .LIC_CLK_EN_O(lic), .PLL_EN_O(pll), .ACK_VALID_O(ackv),
    .ACK_TYPE_O(ackt), .ACK_READY_I(rdy), .EXEC_RUN_O(run), .SAVE_STATE_O(save),
    .HANDLER_FETCH_O(fetch), .INTR_SERVICE_O(isrv), .SYSMGMT_OPERATING_MODE_O(mode),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  chipset_model chipset_model_inst (.clk_i(clk), .stop_i(stop), .sleep_i(sleep), .smi_i(smi),
    .slow_i(slow), .ack_valid_i(ackv), .stop_n_o(stop_n), .sleep_n_o(sleep_n),
    .smi_n_o(smi_n), .ack_ready_o(rdy));
  // Clock and random snoop traffic
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    rnd <= next_rand(rnd);
    snoop <= rnd[3];
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  // Expected status word from grant, latched interrupt, mode, pending
  function automatic logic [31:0] stat(input logic g, ip, m, sp);
    return {24'h0, 1'b0, g, sp, ip, m, 1'b1, 1'b1, !g};
  endfunction : stat
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // Bounded wait, sampling at the falling edge
  task automatic wait_sig(ref logic s, input logic v);
    for (int i = 0; i < 40 && s !== v; i++) @(negedge clk);
    chk("wait", {31'h0, v}, {31'h0, s});
    if (s !== v) stop_test();
  endtask : wait_sig
  task automatic apb(input logic wr, input logic [`LPS_ADDR_W-1:0] a, input logic [31:0] v);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    chk("pready", 32'h1, {31'h0, pready});
    if (pready !== 1'b1) stop_test();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `LPS_CTRL_OFF, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, `LPS_STAT_OFF, 32'h0);
    chk("stat", stat(0, 0, 0, 0), rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    repeat (4) begin
      d = rnd & 32'hFFFFFFFD;
      apb(1'b1, `LPS_CTRL_OFF, d);
      apb(1'b0, `LPS_CTRL_OFF, 32'h0);
      chk("ctrl", {31'h0, d[0]}, rd);
    end
    apb(1'b1, `LPS_CTRL_OFF, 32'h1);
    sleep <= 1'b1;
    repeat (8) @(negedge clk);
    chk("bus", 32'h1, {31'h0, bus});
    @(posedge clk);
    sleep <= 1'b0;
    slow <= 1'b1;
    repeat (4) @(posedge clk);
    stop <= 1'b1;
    wait_sig(ackv, 1'b1);
    chk("ack type", 32'h1, {30'h0, ackt});
    wait_sig(ackv, 1'b0);
    @(posedge clk);
    intr <= 1'b1;
    @(posedge clk);
    intr <= 1'b0;
    apb(1'b0, `LPS_STAT_OFF, 32'h0);
    chk("stat", stat(1, 1, 0, 0), rd);
    sleep <= 1'b1;
    wait_sig(bus, 1'b0);
    chk("lic", 32'h0, {31'h0, lic});
    @(negedge clk);
    chk("snoop", 32'h0, {31'h0, snp});
    // Interrupt edge lands while asleep and must be dropped
    @(posedge clk);
    smi <= 1'b1;
    repeat (4) @(posedge clk);
    sleep <= 1'b0;
    wait_sig(bus, 1'b1);
    chk("core", 32'h0, {31'h0, core});
    @(posedge clk);
    stop <= 1'b0;
    wait_sig(isrv, 1'b1);
    wait_sig(run, 1'b1);
    apb(1'b0, `LPS_STAT_OFF, 32'h0);
    chk("stat", stat(0, 0, 0, 0), rd);
    smi <= 1'b0;
    apb(1'b1, `LPS_CTRL_OFF, 32'h0);
    smi <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, `LPS_STAT_OFF, 32'h0);
    chk("stat", stat(0, 0, 0, 1), rd);
    apb(1'b1, `LPS_CTRL_OFF, 32'h1);
    wait_sig(save, 1'b1);
    wait_sig(fetch, 1'b1);
    chk("mode", 32'h1, {31'h0, mode});
    apb(1'b1, `LPS_CTRL_OFF, 32'h3);
    @(negedge clk);
    chk("mode", 32'h0, {31'h0, mode});
    stop_test();
  end
endmodule : testbench
bind low_power_state_control lps_monitor lps_monitor_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .CLOCK_STOP_REQUEST_N_I(CLOCK_STOP_REQUEST_N_I), .SNOOP_REQ_I(SNOOP_REQ_I),
  .SNOOP_ACK_O(SNOOP_ACK_O), .CORE_CLK_EN_O(CORE_CLK_EN_O), .BUS_CLK_EN_O(BUS_CLK_EN_O),
  .LIC_CLK_EN_O(LIC_CLK_EN_O), .PLL_EN_O(PLL_EN_O), .ACK_VALID_O(ACK_VALID_O),
  .ACK_TYPE_O(ACK_TYPE_O), .ACK_READY_I(ACK_READY_I), .EXEC_RUN_O(EXEC_RUN_O),
  .SAVE_STATE_O(SAVE_STATE_O), .HANDLER_FETCH_O(HANDLER_FETCH_O),
  .SYSMGMT_OPERATING_MODE_O(SYSMGMT_OPERATING_MODE_O));
